// >>> rtl/gpcn_route.sv
// Purpose: Capture input selector from a 7-bit route code
// Assumes: Remap inputs already synchronised
// Notes: Code zero ties to ground, code one picks the comparator
`timescale 1ns/10ps
module gpcn_route
   import gpcn_pkg::*;
#(
   parameter int REMAP_N = GPCN_REMAP_N
) (
   // Selection
   input wire logic [GPCN_RT_W-1:0] code,
   // Sources
   input wire logic [REMAP_N-1:0] remap_in,
   input wire logic comparator_one_output,
   // Result
   output logic sel_out
);
   always_comb begin
      if (code == GPCN_RT_GND) begin
         sel_out = 1'b0;
      end else if (code == GPCN_RT_CMP) begin
         sel_out = comparator_one_output;
      end else begin
         sel_out = remap_in[code];
      end
   end
endmodule

// >>> rtl/gpcn_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs asynchronous to aclk
// Notes: Level moves once stages two and three agree
`timescale 1ns/10ps
module gpcn_sync #(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Pins and result
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] level_q
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            s1_q[i] <= 1'b0;
            s2_q[i] <= 1'b0;
            s3_q[i] <= 1'b0;
            level_q[i] <= 1'b0;
         end else begin
            s1_q[i] <= async_in[i];
            s2_q[i] <= s1_q[i];
            s3_q[i] <= s2_q[i];
            if (s2_q[i] == s3_q[i]) begin
               level_q[i] <= s3_q[i];
            end
         end
      end
   end
endmodule

// >>> rtl/gpcn_top.sv
// Purpose: GPIO port with open-drain, analog select, pulls, change notify
// Assumes: Single 125 MHz aclk, AXI4-Lite register access
// Notes: Change state is kept while clocks stop and flagged on restart
`timescale 1ns/10ps
module gpcn_top
   import gpcn_pkg::*;
#(
   parameter int PINS = GPCN_PINS
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [GPCN_AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [GPCN_AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Port pins
   input wire logic [PINS-1:0] pin_in,
   output logic [PINS-1:0] pin_out,
   output logic [PINS-1:0] pin_oe,
   output logic [PINS-1:0] weak_pullup_en,
   output logic [PINS-1:0] weak_pulldown_en,
   output logic [PINS-1:0] analog_path_en,
   // Capture routing
   input wire logic [GPCN_REMAP_N-1:0] remap_in,
   input wire logic comparator_one_output,
   output logic capture1_in,
   output logic capture2_in,
   // Interrupt
   output logic irq
);
   logic [PINS-1:0] direction_select_q;
   logic [PINS-1:0] output_latch_q;
   logic [PINS-1:0] open_drain_select_q;
   logic [PINS-1:0] analog_select_q;
   logic [PINS-1:0] change_irq_enable_q;
   logic [PINS-1:0] weak_pullup_enable_q;
   logic [PINS-1:0] weak_pulldown_enable_q;
   logic [PINS-1:0] state_change_q;
   logic [PINS-1:0] irq_mask_q;
   logic [PINS-1:0] prev_level_q;
   logic [PINS-1:0] pin_sync;
   logic [PINS-1:0] pin_level;
   logic [PINS-1:0] state_change_ev;
   logic [PINS-1:0] w1c_clr;
   logic [GPCN_REMAP_N-1:0] remap_sync;
   logic [0:0] cmp_sync;
   gpcn_route_t route_q;
   gpcn_wr_st_t wr_st_q;
   gpcn_wr_st_t wr_st_d;
   logic [GPCN_AW-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [GPCN_AW-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic aw_hs;
   logic w_hs;
   logic ar_hs;
   logic wr_fire;
   logic wr_hit;
   logic [31:0] rd_word;
   logic rd_hit;
   logic cap1_sel;
   logic cap2_sel;

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
      logic [15:0] r;
      r = old;
      if (s[0]) begin
         r[7:0] = d[7:0];
      end
      if (s[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction

   // Input synchronisers
   gpcn_sync #(.WIDTH(PINS)) u_pin_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in(pin_in),
      .level_q(pin_sync)
   );
   gpcn_sync #(.WIDTH(GPCN_REMAP_N)) u_remap_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in(remap_in),
      .level_q(remap_sync)
   );
   gpcn_sync #(.WIDTH(1)) u_cmp_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in(comparator_one_output),
      .level_q(cmp_sync)
   );

   gpcn_route u_route_c1 (
      .code(route_q.cap1),
      .remap_in(remap_sync),
      .comparator_one_output(cmp_sync[0]),
      .sel_out(cap1_sel)
   );
   gpcn_route u_route_c2 (
      .code(route_q.cap2),
      .remap_in(remap_sync),
      .comparator_one_output(cmp_sync[0]),
      .sel_out(cap2_sel)
   );

   // Write channel sequencing
   assign aw_hs = awvalid && awready;
   assign w_hs = wvalid && wready;
   assign ar_hs = arvalid && arready;

   always_comb begin
      wr_st_d = wr_st_q;
      case (wr_st_q)
         GPCN_W_IDLE: begin
            if (aw_hs && w_hs) begin
               wr_st_d = GPCN_W_RESP;
            end else if (aw_hs) begin
               wr_st_d = GPCN_W_HAVE_AW;
            end else if (w_hs) begin
               wr_st_d = GPCN_W_HAVE_W;
            end
         end
         GPCN_W_HAVE_AW: begin
            if (w_hs) begin
               wr_st_d = GPCN_W_RESP;
            end
         end
         GPCN_W_HAVE_W: begin
            if (aw_hs) begin
               wr_st_d = GPCN_W_RESP;
            end
         end
         GPCN_W_RESP: begin
            if (bready) begin
               wr_st_d = GPCN_W_IDLE;
            end
         end
         default: wr_st_d = GPCN_W_IDLE;
      endcase
   end

   assign wr_fire = (wr_st_d == GPCN_W_RESP) && (wr_st_q != GPCN_W_RESP);
   assign wr_addr = aw_hs ? awaddr : awaddr_q;
   assign wr_data = w_hs ? wdata : wdata_q;
   assign wr_strb = w_hs ? wstrb : wstrb_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_st_q <= GPCN_W_IDLE;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= GPCN_RESP_OKAY;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else begin
         wr_st_q <= wr_st_d;
         awready <= (wr_st_d == GPCN_W_IDLE) || (wr_st_d == GPCN_W_HAVE_W);
         wready <= (wr_st_d == GPCN_W_IDLE) || (wr_st_d == GPCN_W_HAVE_AW);
         bvalid <= (wr_st_d == GPCN_W_RESP);
         if (aw_hs) begin
            awaddr_q <= awaddr;
         end
         if (w_hs) begin
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
         if (wr_fire) begin
            bresp <= wr_hit ? GPCN_RESP_OKAY : GPCN_RESP_SLVERR;
         end
      end
   end

   always_comb begin
      wr_hit = 1'b1;
      case (wr_addr)
         GPCN_OFS_DIR, GPCN_OFS_LAT, GPCN_OFS_LVL, GPCN_OFS_OD, GPCN_OFS_ANA,
         GPCN_OFS_CNEN, GPCN_OFS_PU, GPCN_OFS_PD, GPCN_OFS_ROUTE, GPCN_OFS_STAT,
         GPCN_OFS_MASK: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // Configuration registers; pin level writes land in the latch
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         direction_select_q <= GPCN_RST_DIR;
         output_latch_q <= GPCN_RST_ZERO;
         open_drain_select_q <= GPCN_RST_ZERO;
         analog_select_q <= GPCN_RST_ANA;
         change_irq_enable_q <= GPCN_RST_ZERO;
         weak_pullup_enable_q <= GPCN_RST_ZERO;
         weak_pulldown_enable_q <= GPCN_RST_ZERO;
         irq_mask_q <= GPCN_RST_ZERO;
         route_q <= GPCN_RST_ZERO;
      end else if (wr_fire) begin
         case (wr_addr)
            GPCN_OFS_DIR: direction_select_q <= merge16(direction_select_q, wr_data, wr_strb);
            GPCN_OFS_LAT, GPCN_OFS_LVL: begin
               output_latch_q <= merge16(output_latch_q, wr_data, wr_strb);
            end
            GPCN_OFS_OD: open_drain_select_q <= merge16(open_drain_select_q, wr_data, wr_strb);
            GPCN_OFS_ANA: analog_select_q <= merge16(analog_select_q, wr_data, wr_strb);
            GPCN_OFS_CNEN: begin
               change_irq_enable_q <= merge16(change_irq_enable_q, wr_data, wr_strb);
            end
            GPCN_OFS_PU: begin
               weak_pullup_enable_q <= merge16(weak_pullup_enable_q, wr_data, wr_strb);
            end
            GPCN_OFS_PD: begin
               weak_pulldown_enable_q <= merge16(weak_pulldown_enable_q, wr_data, wr_strb);
            end
            GPCN_OFS_ROUTE: begin
               route_q <= merge16(route_q, wr_data, wr_strb) & 16'h7F7F;
            end
            GPCN_OFS_MASK: irq_mask_q <= merge16(irq_mask_q, wr_data, wr_strb);
            default: ;
         endcase
      end
   end

   // Change detection and sticky flags; a new change beats a clear
   assign state_change_ev = (pin_sync ^ prev_level_q) & change_irq_enable_q;
   assign w1c_clr = (wr_fire && wr_addr == GPCN_OFS_STAT) ?
                    merge16(GPCN_RST_ZERO, wr_data, wr_strb) : GPCN_RST_ZERO;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_level_q <= GPCN_RST_ZERO;
         state_change_q <= GPCN_RST_ZERO;
         irq <= 1'b0;
      end else begin
         prev_level_q <= pin_sync;
         state_change_q <= (state_change_q & ~w1c_clr) | state_change_ev;
         irq <= |(((state_change_q & ~w1c_clr) | state_change_ev) & irq_mask_q);
      end
   end

   // Pad drive, pulls, analog path and capture routes
   assign pin_level = pin_sync & ~(analog_select_q & direction_select_q);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out <= '0;
         pin_oe <= '0;
         weak_pullup_en <= '0;
         weak_pulldown_en <= '0;
         analog_path_en <= '0;
         capture1_in <= 1'b0;
         capture2_in <= 1'b0;
      end else begin
         pin_out <= output_latch_q & ~open_drain_select_q;
         pin_oe <= ~direction_select_q & (~open_drain_select_q | ~output_latch_q);
         weak_pullup_en <= weak_pullup_enable_q;
         weak_pulldown_en <= weak_pulldown_enable_q;
         analog_path_en <= analog_select_q;
         capture1_in <= cap1_sel;
         capture2_in <= cap2_sel;
      end
   end

   // Read channel
   always_comb begin
      rd_word = '0;
      rd_hit = 1'b1;
      case (araddr)
         GPCN_OFS_DIR: rd_word[15:0] = direction_select_q;
         GPCN_OFS_LAT: rd_word[15:0] = output_latch_q;
         GPCN_OFS_LVL: rd_word[15:0] = pin_level;
         GPCN_OFS_OD: rd_word[15:0] = open_drain_select_q;
         GPCN_OFS_ANA: rd_word[15:0] = analog_select_q;
         GPCN_OFS_CNEN: rd_word[15:0] = change_irq_enable_q;
         GPCN_OFS_PU: rd_word[15:0] = weak_pullup_enable_q;
         GPCN_OFS_PD: rd_word[15:0] = weak_pulldown_enable_q;
         GPCN_OFS_ROUTE: rd_word[15:0] = route_q;
         GPCN_OFS_STAT: rd_word[15:0] = state_change_q;
         GPCN_OFS_MASK: rd_word[15:0] = irq_mask_q;
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= GPCN_RESP_OKAY;
      end else if (ar_hs) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rd_word;
         rresp <= rd_hit ? GPCN_RESP_OKAY : GPCN_RESP_SLVERR;
      end else if (rvalid && rready) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
      end else if (!rvalid) begin
         arready <= 1'b1;
      end
   end

   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_rd_level;
      ar_hs && (araddr == GPCN_OFS_LVL);
   endsequence
   sequence s_route_wr;
      wr_fire && (wr_addr == GPCN_OFS_ROUTE);
   endsequence

   property p_od_low_only;
      1 |=> ((pin_out & $past(open_drain_select_q)) == '0);
   endproperty
   a_od_low_only: assert property (p_od_low_only) else $error("open-drain pin driven high");
   property p_ana_reset;
      $past(!aresetn) |-> (analog_select_q == GPCN_RST_ANA);
   endproperty
   a_ana_reset: assert property (p_ana_reset) else $error("analog select reset wrong");
   property p_ana_out_drives;
      1 |=> ((~$past(direction_select_q) & ~$past(open_drain_select_q) & ~pin_oe) == '0);
   endproperty
   a_ana_out_drives: assert property (p_ana_out_drives) else $error("output not driven");
   property p_ana_read_zero;
      s_rd_level |=> ((rdata[15:0] & $past(analog_select_q & direction_select_q)) == '0);
   endproperty
   a_ana_read_zero: assert property (p_ana_read_zero) else $error("analog pin read nonzero");
   property p_dig_no_analog;
      1 |=> ((analog_path_en & ~$past(analog_select_q)) == '0);
   endproperty
   a_dig_no_analog: assert property (p_dig_no_analog) else $error("digital pin on analog path");
   property p_change_flag;
      (state_change_ev != '0) |=> ((state_change_q & $past(state_change_ev)) != '0);
   endproperty
   a_change_flag: assert property (p_change_flag) else $error("change not flagged");
   property p_irq_level;
      ((state_change_q & irq_mask_q) != '0) && (w1c_clr == '0) |=> irq;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");
   property p_cn_gate;
      1 |=> ((state_change_q & ~$past(state_change_q) & ~$past(change_irq_enable_q)) == '0);
   endproperty
   a_cn_gate: assert property (p_cn_gate) else $error("disabled pin flagged a change");
   property p_pulls;
      1 |=> (weak_pullup_en == $past(weak_pullup_enable_q)) &&
            (weak_pulldown_en == $past(weak_pulldown_enable_q));
   endproperty
   a_pulls: assert property (p_pulls) else $error("pull enable mismatch");
   property p_route_rsv;
      s_route_wr |=> (route_q.rsv_hi == 1'b0) && (route_q.rsv_lo == 1'b0);
   endproperty
   a_route_rsv: assert property (p_route_rsv) else $error("route reserved bit set");
   property p_route_gnd;
      (route_q.cap2 == GPCN_RT_GND) |=> !capture2_in;
   endproperty
   a_route_gnd: assert property (p_route_gnd) else $error("ground route not low");
endmodule

// >>> shared/gpcn_pkg.sv
// Purpose: Shared constants and types of the GPIO port with change notify
// Assumes: 16-bit port, registers on 32-bit AXI4-Lite words
// Notes: Reserved register bits read as zero
package gpcn_pkg;
   localparam int GPCN_PINS = 16;
   localparam int GPCN_AW = 8;
   localparam int GPCN_RT_W = 7;
   localparam int GPCN_REMAP_N = 128;
   // Register byte offsets
   localparam logic [7:0] GPCN_OFS_DIR = 8'h00;
   localparam logic [7:0] GPCN_OFS_LAT = 8'h04;
   localparam logic [7:0] GPCN_OFS_LVL = 8'h08;
   localparam logic [7:0] GPCN_OFS_OD = 8'h0C;
   localparam logic [7:0] GPCN_OFS_ANA = 8'h10;
   localparam logic [7:0] GPCN_OFS_CNEN = 8'h14;
   localparam logic [7:0] GPCN_OFS_PU = 8'h18;
   localparam logic [7:0] GPCN_OFS_PD = 8'h1C;
   localparam logic [7:0] GPCN_OFS_ROUTE = 8'h20;
   localparam logic [7:0] GPCN_OFS_STAT = 8'h24;
   localparam logic [7:0] GPCN_OFS_MASK = 8'h28;
   // Reset values
   localparam logic [15:0] GPCN_RST_ANA = 16'hFFFF;
   localparam logic [15:0] GPCN_RST_DIR = 16'hFFFF;
   localparam logic [15:0] GPCN_RST_ZERO = 16'h0000;
   // Route field positions and codes, AXI response codes
   localparam int GPCN_CAP1_LSB = 0;
   localparam int GPCN_CAP2_LSB = 8;
   localparam logic [6:0] GPCN_RT_GND = 7'h00;
   localparam logic [6:0] GPCN_RT_CMP = 7'h01;
   localparam logic [6:0] GPCN_RT_REMAP121 = 7'h79;
   localparam logic [1:0] GPCN_RESP_OKAY = 2'h0;
   localparam logic [1:0] GPCN_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic rsv_hi;
      logic [6:0] cap2;
      logic rsv_lo;
      logic [6:0] cap1;
   } gpcn_route_t;

   typedef enum logic [1:0] {
      GPCN_W_IDLE = 2'b00,
      GPCN_W_HAVE_AW = 2'b01,
      GPCN_W_HAVE_W = 2'b10,
      GPCN_W_RESP = 2'b11
   } gpcn_wr_st_t;
endpackage

// >>> test/gpcn_pad_model.sv
// Purpose: Pad and external circuit model for the GPIO port pins
// Assumes: An enabled pad driver overrides any external driver on the pin
// Notes: A floating pin with no pull shows a level that toggles each cycle
`timescale 1ns/10ps
module gpcn_pad_model (
   // Clock
   input wire logic aclk,
   // Pad side of the block
   input wire logic [15:0] pin_out,
   input wire logic [15:0] pin_oe,
   input wire logic [15:0] weak_pullup_en,
   input wire logic [15:0] weak_pulldown_en,
   // External circuit
   input wire logic [15:0] ext_en,
   input wire logic [15:0] ext_val,
   // Resolved wire level
   output logic [15:0] pin_in
);
   logic [15:0] float_q = 16'h0000;

   // Unknown never settles silently to a level
   always_ff @(posedge aclk) begin
      float_q <= ~pin_in;
   end

   always_comb begin
      for (int i = 0; i < 16; i++) begin
         if (pin_oe[i]) pin_in[i] = pin_out[i];
         else if (ext_en[i]) pin_in[i] = ext_val[i];
         else if (weak_pullup_en[i]) pin_in[i] = 1'b1;
         else if (weak_pulldown_en[i]) pin_in[i] = 1'b0;
         else pin_in[i] = float_q[i];
      end
   end
endmodule

// >>> test/gpio_port_change_notify_bench.sv
// Purpose: Self-checking bench for the GPIO port with change notify
// Assumes: AXI4-Lite master tasks, pad model on the pins
// Notes: Sync latency of four edges covered by eight-cycle waits
`timescale 1ns/10ps
module gpio_port_change_notify_bench;
   import gpcn_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid, irq, cap1, cap2;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, rd;
   logic [15:0] pin_in, pin_out, pin_oe, pu, pd, ana_en;
   logic [15:0] ext_en = 16'h0000, ext_val = 16'h0000;
   logic [127:0] remap_in = '0;
   logic comp = 1'b0;
   int n_fail = 0, check_count = 0, cyc = 0;

   always #4 aclk = ~aclk;

   gpcn_top i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .weak_pullup_en(pu),
      .weak_pulldown_en(pd), .analog_path_en(ana_en), .remap_in(remap_in),
      .comparator_one_output(comp), .capture1_in(cap1), .capture2_in(cap2), .irq(irq));

   gpcn_pad_model i_pads (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
      .weak_pullup_en(pu), .weak_pulldown_en(pd), .ext_en(ext_en), .ext_val(ext_val),
      .pin_in(pin_in));

   task automatic final_report();
      $display("Checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         final_report();
      end
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         n_fail++;
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // Handshakes judged on values held just before the rising edge
   task automatic axi_write(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
      logic aw_go, w_go, b_go;
      b_go = 1'b0;
      awaddr <= a;
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b_go) begin
         @(negedge aclk);
         aw_go = awvalid && awready;
         w_go = wvalid && wready;
         b_go = bvalid;
         r = bresp;
         @(posedge aclk);
         if (aw_go) awvalid <= 1'b0;
         if (w_go) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      // Let an edge pass so the next call never re-raises bready in this step
      @(posedge aclk);
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_go, r_go;
      r_go = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!r_go) begin
         @(negedge aclk);
         ar_go = arvalid && arready;
         r_go = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ar_go) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      axi_write(a, d, resp);
      check("bresp", GPCN_RESP_OKAY, resp);
   endtask

   task automatic rd_check(input string what, input logic [7:0] a, input logic [31:0] exp);
      axi_read(a, rd, resp);
      check(what, exp, rd);
   endtask

   task automatic t_reset_values();
      rd_check("dir reset", GPCN_OFS_DIR, 32'h0000_FFFF);
      rd_check("analog reset", GPCN_OFS_ANA, 32'h0000_FFFF);
      rd_check("route reset", GPCN_OFS_ROUTE, 32'h0000_0000);
      rd_check("level analog in", GPCN_OFS_LVL, 32'h0000_0000);
      axi_read(8'h40, rd, resp);
      check("unmapped rresp", GPCN_RESP_SLVERR, resp);
      axi_write(8'h40, 16'h1234, resp);
      check("unmapped bresp", GPCN_RESP_SLVERR, resp);
   endtask

   task automatic t_outputs();
      wr(GPCN_OFS_ANA, 16'h0000);
      wr(GPCN_OFS_DIR, 16'h0000);
      wr(GPCN_OFS_LAT, 16'hA5A5);
      cycles(8);
      check("push pull oe", 32'h0000_FFFF, pin_oe);
      check("push pull out", 32'h0000_A5A5, pin_out);
      rd_check("level outputs", GPCN_OFS_LVL, 32'h0000_A5A5);
      wr(GPCN_OFS_OD, 16'hFFFF);
      cycles(2);
      check("open drain out", 32'h0000_0000, pin_out);
      check("open drain oe", 32'h0000_5A5A, pin_oe);
      wr(GPCN_OFS_OD, 16'h0000);
      wr(GPCN_OFS_ANA, 16'hFFFF);
      cycles(2);
      check("analog out oe", 32'h0000_FFFF, pin_oe);
      check("analog out drive", 32'h0000_A5A5, pin_out);
      check("analog path", 32'h0000_FFFF, ana_en);
      ext_en <= 16'hFFFF;
      ext_val <= 16'hFFFF;
      wr(GPCN_OFS_DIR, 16'hFFFF);
      cycles(8);
      rd_check("level analog in", GPCN_OFS_LVL, 32'h0000_0000);
   endtask

   task automatic t_pulls();
      ext_en <= 16'h0000;
      wr(GPCN_OFS_ANA, 16'h0000);
      wr(GPCN_OFS_PU, 16'h00FF);
      wr(GPCN_OFS_PD, 16'hFF00);
      cycles(8);
      check("pullup en", 32'h0000_00FF, pu);
      check("pulldown en", 32'h0000_FF00, pd);
      check("digital no analog", 32'h0000_0000, ana_en);
      rd_check("level pulls", GPCN_OFS_LVL, 32'h0000_00FF);
      wr(GPCN_OFS_PU, 16'h0000);
      wr(GPCN_OFS_PD, 16'h0000);
   endtask

   task automatic t_change();
      ext_en <= 16'hFFFF;
      ext_val <= 16'h0000;
      cycles(8);
      wr(GPCN_OFS_CNEN, 16'h8001);
      wr(GPCN_OFS_MASK, 16'h8001);
      wr(GPCN_OFS_STAT, 16'hFFFF);
      cycles(2);
      check("irq idle", 32'h0000_0000, irq);
      ext_val <= 16'h8003;
      cycles(8);
      rd_check("change status", GPCN_OFS_STAT, 32'h0000_8001);
      check("irq change", 32'h0000_0001, irq);
      wr(GPCN_OFS_MASK, 16'h0000);
      cycles(2);
      check("irq masked", 32'h0000_0000, irq);
      wr(GPCN_OFS_MASK, 16'h8001);
      wr(GPCN_OFS_STAT, 16'h8001);
      cycles(2);
      check("irq cleared", 32'h0000_0000, irq);
      rd_check("status cleared", GPCN_OFS_STAT, 32'h0000_0000);
      ext_val <= 16'h8002;
      cycles(8);
      rd_check("change fall", GPCN_OFS_STAT, 32'h0000_0001);
      check("irq fall", 32'h0000_0001, irq);
      wr(GPCN_OFS_STAT, 16'hFFFF);
   endtask

   task automatic t_route();
      logic [6:0] codes [3];
      logic [6:0] c;
      logic e;
      codes = '{GPCN_RT_GND, GPCN_RT_CMP, GPCN_RT_REMAP121};
      wr(GPCN_OFS_ROUTE, 16'hFFFF);
      rd_check("route reserved", GPCN_OFS_ROUTE, 32'h0000_7F7F);
      for (int p = 0; p < 2; p++) begin
         comp <= (p == 0);
         remap_in <= (p == 0) ? {6'h00, 1'b1, 121'h0} : ~{6'h00, 1'b1, 121'h0};
         for (int k = 0; k < 3; k++) begin
            c = codes[k];
            e = (k == 0) ? 1'b0 : (p == 0);
            wr(GPCN_OFS_ROUTE, {1'b0, c, 1'b0, c});
            cycles(6);
            check("capture2", {31'h0, e}, cap2);
            check("capture1", {31'h0, e}, cap1);
         end
      end
   endtask

   initial begin
      cycles(20);
      aresetn <= 1'b1;
      cycles(2);
      t_reset_values();
      t_outputs();
      t_pulls();
      t_change();
      t_route();
      final_report();
   end
endmodule
